// ===== lim_pkg.sv
// Purpose: Constants and types for the supply tracking output limiter
// Assumes: 50 MHz clk_i, 24-bit signed samples, 8-bit register port
// Notes: Level tables are plain constants so steps can be retuned
`default_nettype none
package lim_pkg;
    localparam logic [7:0] ADDR_VBAT = 8'h06;
    localparam logic [7:0] ADDR_CTL_ONE = 8'h07;
    localparam logic [7:0] ADDR_CTL_TWO = 8'h08;
    localparam logic [7:0] ADDR_KNEE = 8'h09;
    localparam logic [7:0] RST_CTL_ONE = 8'hA4;
    localparam logic [7:0] RST_CTL_TWO = 8'h51;
    localparam logic [7:0] RST_KNEE = 8'h22;
    localparam int MODE_LSB = 0;
    localparam int TRACK_BIT = 2;
    localparam int ATTACK_LSB = 4;
    localparam int RELEASE_LSB = 6;
    localparam int SLOPE_LSB = 0;
    localparam int THR_LSB = 3;
    localparam logic [13:0] KNEE_BASE_MV = 14'd3800;
    // 12400 / 255 scaled by 256
    localparam logic [21:0] KNEE_MUL = 22'd12449;
    localparam logic [13:0] HYST_MV = 14'd200;
    // LSBs per mV for 15 V full-scale mapping
    localparam logic [23:0] MV_TO_LSB = 24'd559;
    localparam int AVG_SHIFT = 6;
    localparam logic [15:0] GAIN_UNITY = 16'h8000;
    localparam logic [13:0] THR_MV_TABLE [32] = '{
        14'd1000, 14'd1452, 14'd1903, 14'd2355, 14'd2806, 14'd3258, 14'd3710, 14'd4161,
        14'd4613, 14'd5065, 14'd5516, 14'd5968, 14'd6419, 14'd6871, 14'd7323, 14'd7774,
        14'd8226, 14'd8677, 14'd9129, 14'd9581, 14'd10032, 14'd10484, 14'd10935, 14'd11387,
        14'd11839, 14'd12290, 14'd12742, 14'd13194, 14'd13645, 14'd14097, 14'd14548, 14'd15000};
    localparam logic [15:0] SLOPE_TABLE [4] = '{16'd1, 16'd2, 16'd3, 16'd4};
    localparam logic [15:0] ATTACK_TABLE [4] = '{16'h0800, 16'h0200, 16'h0080, 16'h0020};
    localparam logic [15:0] RELEASE_TABLE [4] = '{16'h0040, 16'h0010, 16'h0004, 16'h0001};
    typedef enum logic [1:0] {
        MODE_OFF = 2'b00,
        MODE_ALWAYS = 2'b01,
        MODE_MUTE_LOW = 2'b10,
        MODE_LOW_ONLY = 2'b11
    } lim_mode_type;
    typedef enum logic [1:0] {
        SUPPLY_ABOVE = 2'b01,
        SUPPLY_BELOW = 2'b10
    } lim_supply_type;
    typedef struct packed {
        logic valid;
        logic signed [23:0] data;
    } lim_sample_type;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lim_reg_req_type;
endpackage
`default_nettype wire

// ===== lim_limiter.sv
// Purpose: Output limiter with battery supply tracking threshold
// Assumes: Battery code comes from converter logic on clk_i
// Notes: Gain is Q1.15, one update per valid sample
`timescale 1ns/10ps
`default_nettype none
module lim_limiter
    import lim_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire lim_reg_req_type reg_req_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    input wire logic [7:0] vbat_code_i,
    input wire lim_sample_type sample_i,
    output lim_sample_type sample_o,
    output logic engaged_o
);
    logic [7:0] ctl_one;
    logic [7:0] ctl_two;
    logic [7:0] knee_reg;
    logic [7:0] vbat_code;
    logic [23:0] avg;
    logic [15:0] gain;
    lim_supply_type supply;
    lim_supply_type next_supply;

    // Register fields
    wire lim_mode_type limiter_mode_select = lim_mode_type'(ctl_one[MODE_LSB +: 2]);
    wire track_sel = ctl_one[TRACK_BIT];
    wire [1:0] attack_rate_sel = ctl_one[ATTACK_LSB +: 2];
    wire [1:0] release_rate_sel = ctl_one[RELEASE_LSB +: 2];
    wire [4:0] threshold_level = ctl_two[THR_LSB +: 5];
    wire [1:0] slope_sel = ctl_two[SLOPE_LSB +: 2];
    wire [7:0] supply_knee_level = knee_reg;

    // Register port decode
    wire wr_ctl_one = reg_req_i.wr && (reg_req_i.addr == ADDR_CTL_ONE);
    wire wr_ctl_two = reg_req_i.wr && (reg_req_i.addr == ADDR_CTL_TWO);
    wire wr_knee = reg_req_i.wr && (reg_req_i.addr == ADDR_KNEE);
    logic [7:0] rd_mux;
    always_comb begin
        unique case (reg_req_i.addr)
            ADDR_VBAT: rd_mux = vbat_code;
            ADDR_CTL_ONE: rd_mux = ctl_one;
            ADDR_CTL_TWO: rd_mux = ctl_two;
            ADDR_KNEE: rd_mux = knee_reg;
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctl_one <= RST_CTL_ONE;
            ctl_two <= RST_CTL_TWO;
            knee_reg <= RST_KNEE;
            reg_rdata_o <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end else begin
            if (wr_ctl_one) begin
                ctl_one <= reg_req_i.wdata;
            end
            if (wr_ctl_two) begin
                ctl_two <= reg_req_i.wdata;
            end
            if (wr_knee) begin
                knee_reg <= reg_req_i.wdata;
            end
            reg_rvalid_o <= reg_req_i.rd;
            if (reg_req_i.rd) begin
                reg_rdata_o <= rd_mux;
            end
        end
    end

    // Battery code capture, register 0x06 is read-only
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            vbat_code <= 8'h00;
        end else begin
            vbat_code <= vbat_code_i;
        end
    end

    // Code to millivolts, same scale for knee and battery
    wire [21:0] knee_prod = 22'(supply_knee_level) * KNEE_MUL;
    wire [21:0] vbat_prod = 22'(vbat_code) * KNEE_MUL;
    wire [13:0] knee_mv = KNEE_BASE_MV + knee_prod[21:8];
    wire [13:0] vbat_mv = KNEE_BASE_MV + vbat_prod[21:8];
    // One bit wider so a top knee code cannot wrap the release point
    wire [14:0] release_mv = 15'(knee_mv) + 15'(HYST_MV);
    wire vbat_low = vbat_mv < knee_mv;
    wire vbat_clear = 15'(vbat_mv) > release_mv;

    // Hysteresis keeps the mode from chattering on a noisy supply
    always_comb begin
        next_supply = supply;
        unique case (supply)
            SUPPLY_ABOVE: begin
                if (vbat_low) begin
                    next_supply = SUPPLY_BELOW;
                end
            end
            SUPPLY_BELOW: begin
                if (vbat_clear) begin
                    next_supply = SUPPLY_ABOVE;
                end
            end
            default: next_supply = SUPPLY_ABOVE;
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            supply <= SUPPLY_ABOVE;
        end else begin
            supply <= next_supply;
        end
    end

    wire below = (supply == SUPPLY_BELOW);

    // Threshold selection
    wire [13:0] set_mv = THR_MV_TABLE[threshold_level];
    wire [13:0] deficit_mv = vbat_low ? (knee_mv - vbat_mv) : 14'd0;
    wire [15:0] red_mv = 16'(deficit_mv) * SLOPE_TABLE[slope_sel];
    wire [13:0] low_mv = (red_mv >= 16'(set_mv)) ? 14'd0 : (set_mv - red_mv[13:0]);
    wire track_mode = (limiter_mode_select == MODE_ALWAYS) || (limiter_mode_select == MODE_LOW_ONLY);
    wire use_low = track_sel && below && track_mode;
    wire [13:0] act_mv = use_low ? low_mv : set_mv;
    // Top threshold 15000 mV maps just under full scale, so a full-scale sample still trips it
    wire [23:0] thr_lsb = 24'(act_mv) * MV_TO_LSB;

    logic limit_on;
    always_comb begin
        unique case (limiter_mode_select)
            MODE_OFF: limit_on = 1'b0;
            MODE_ALWAYS: limit_on = 1'b1;
            MODE_MUTE_LOW: limit_on = 1'b1;
            MODE_LOW_ONLY: limit_on = below;
        endcase
    end
    wire mute = (limiter_mode_select == MODE_MUTE_LOW) && below;

    // Level detection: peak and a mean-abs rms estimate
    wire sign = sample_i.data[23];
    wire [23:0] raw = sample_i.data;
    wire [23:0] mag = sign ? (24'h00_0000 - raw) : raw;
    wire signed [24:0] avg_diff = $signed({1'b0, mag}) - $signed({1'b0, avg});
    wire signed [24:0] avg_step = avg_diff >>> AVG_SHIFT;
    wire [24:0] next_avg_wide = 25'($signed({1'b0, avg}) + avg_step);
    wire [23:0] next_avg = next_avg_wide[23:0];
    // Mean-abs times 1.125 approximates sine rms without a root
    wire [24:0] rms_wide = {1'b0, avg} + {4'h0, avg[23:3]};
    wire [23:0] rms_est = rms_wide[24] ? 24'hFF_FFFF : rms_wide[23:0];
    wire [23:0] level = (mag > rms_est) ? mag : rms_est;
    wire over = limit_on && (level > thr_lsb);

    // Gain ramp, clamped so one step never passes its target
    wire [15:0] atk_step = ATTACK_TABLE[attack_rate_sel];
    wire [15:0] rel_step = RELEASE_TABLE[release_rate_sel];
    wire [16:0] gain_up = {1'b0, gain} + {1'b0, rel_step};
    wire [15:0] gain_dn = (gain > atk_step) ? (gain - atk_step) : 16'h0000;
    wire [15:0] gain_rel = (gain_up >= {1'b0, GAIN_UNITY}) ? GAIN_UNITY : gain_up[15:0];
    logic [15:0] next_gain;
    always_comb begin
        if (!limit_on) begin
            next_gain = GAIN_UNITY;
        end else if (over) begin
            next_gain = gain_dn;
        end else begin
            next_gain = gain_rel;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            avg <= 24'h00_0000;
            gain <= GAIN_UNITY;
        end else if (sample_i.valid) begin
            avg <= next_avg;
            gain <= next_gain;
        end
    end

    // Gain apply, then hard clamp so peaks between updates stay held
    wire signed [40:0] prod = sample_i.data * $signed({1'b0, gain});
    wire signed [23:0] scaled = prod[38:15];
    wire signed [24:0] cap_pos = $signed({1'b0, thr_lsb});
    wire signed [24:0] cap_neg = -cap_pos;
    wire signed [24:0] scaled_ext = 25'(scaled);
    logic signed [23:0] next_out;
    always_comb begin
        if (mute) begin
            next_out = 24'sh00_0000;
        end else if (!limit_on) begin
            next_out = sample_i.data;
        end else if (scaled_ext > cap_pos) begin
            next_out = cap_pos[23:0];
        end else if (scaled_ext < cap_neg) begin
            next_out = cap_neg[23:0];
        end else begin
            next_out = scaled;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sample_o <= '0;
            engaged_o <= 1'b0;
        end else begin
            sample_o.valid <= sample_i.valid;
            if (sample_i.valid) begin
                sample_o.data <= next_out;
                engaged_o <= over || mute || (next_gain != GAIN_UNITY);
            end
        end
    end
endmodule // lim_limiter
`default_nettype wire

// ===== lim_checker.sv
// Purpose: Port checks for lim_limiter
// Assumes: One clock, control bytes mirrored from write strobes
// Notes: Clamp check covers fixed threshold only, tracking is left to the bench
`timescale 1ns/10ps
`default_nettype none
module lim_checker
    import lim_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire lim_reg_req_type reg_req_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic reg_rvalid_o,
    input wire logic [7:0] vbat_code_i,
    input wire lim_sample_type sample_i,
    input wire lim_sample_type sample_o,
    input wire logic engaged_o
);
    logic [7:0] ctl_one;
    logic [7:0] ctl_two;
    int thr_lsb;
    int mag;
    wire unmapped = reg_req_i.addr < ADDR_VBAT || reg_req_i.addr > ADDR_KNEE;
    assign thr_lsb = int'(THR_MV_TABLE[ctl_two[7:3]]) * int'(MV_TO_LSB);
    assign mag = sample_o.data < 0 ? -int'(sample_o.data) : int'(sample_o.data);
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctl_one <= RST_CTL_ONE;
            ctl_two <= RST_CTL_TWO;
        end else if (reg_req_i.wr) begin
            if (reg_req_i.addr == ADDR_CTL_ONE) ctl_one <= reg_req_i.wdata;
            if (reg_req_i.addr == ADDR_CTL_TWO) ctl_two <= reg_req_i.wdata;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    sequence s_read(a); reg_req_i.rd && reg_req_i.addr == a; endsequence
    sequence s_take; sample_i.valid; endsequence
    a_read_answer: assert property (reg_req_i.rd |=> reg_rvalid_o)
        else $error("read not answered");
    a_answer_cause: assert property (reg_rvalid_o |-> $past(reg_req_i.rd))
        else $error("answer without read");
    // First edge after reset excluded: the battery copy has not loaded yet
    a_battery_read: assert property (s_read(ADDR_VBAT) ##0 $stable(vbat_code_i) && $past(reset_n_i)
        |=> reg_rdata_o == $past(vbat_code_i)) else $error("battery code wrong");
    a_unmapped_zero: assert property (reg_req_i.rd && unmapped |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_ctl_readback: assert property (s_read(ADDR_CTL_ONE) |=> reg_rdata_o == $past(ctl_one))
        else $error("control readback wrong");
    a_sample_latency: assert property (s_take |=> sample_o.valid)
        else $error("sample not answered");
    a_sample_cause: assert property (sample_o.valid |-> $past(sample_i.valid))
        else $error("spurious output sample");
    a_bypass_off: assert property (s_take ##0 ctl_one[1:0] == 2'b00
        |=> sample_o.data == $past(sample_i.data)) else $error("mode off altered data");
    a_fixed_clamp: assert property (s_take ##0 ctl_one[1:0] == 2'b01 && !ctl_one[2]
        |=> mag <= $past(thr_lsb)) else $error("output above threshold");
    a_data_holds: assert property (!sample_o.valid |-> $stable(sample_o.data))
        else $error("output data moved between samples");
    a_engaged_off: assert property (s_take ##0 ctl_one[1:0] == 2'b00 |=> !engaged_o)
        else $error("engaged while mode off");
endmodule // lim_checker
bind lim_limiter lim_checker lim_checker_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .reg_req_i(reg_req_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .vbat_code_i(vbat_code_i), .sample_i(sample_i),
    .sample_o(sample_o), .engaged_o(engaged_o));
`default_nettype wire

// ===== lim_sample_src.sv
// Purpose: Serial port side that hands samples to the limiter
// Assumes: One sample per go pulse
// Notes: Idle data scrambles so stale values never pass for fresh ones
`timescale 1ns/10ps
`default_nettype none
module lim_sample_src
    import lim_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic go_i,
    input wire logic signed [23:0] data_i,
    output lim_sample_type sample_o
);
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sample_o <= '0;
        end else begin
            sample_o.valid <= go_i;
            sample_o.data <= go_i ? data_i : ~sample_o.data;
        end
    end
endmodule // lim_sample_src
`default_nettype wire

// ===== lim_limiter_bench.sv
// Purpose: Self-checking bench for lim_limiter
// Assumes: Only small or cap-clamped samples are compared exactly once limiting can act
// Notes: Tracking checked at full threshold, gain already reduced on the second slope pass
`timescale 1ns/10ps
`default_nettype none
module lim_limiter_bench
    import lim_pkg::*;
;
    logic clk_i;
    logic reset_n_i;
    lim_reg_req_type req;
    logic [7:0] rdata;
    logic rvalid;
    logic [7:0] vbat;
    logic go;
    logic signed [23:0] din;
    lim_sample_type smp_in;
    lim_sample_type smp_out;
    logic engaged;
    int n_mismatch;
    int tests_run;
    int seed;
    int mode;
    int below;
    int cap;
    int regm[int];
    int expq[$];
    lim_sample_src lim_sample_src_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .go_i(go), .data_i(din),
        .sample_o(smp_in));
    lim_limiter lim_limiter_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .reg_req_i(req), .reg_rdata_o(rdata),
        .reg_rvalid_o(rvalid), .vbat_code_i(vbat), .sample_i(smp_in), .sample_o(smp_out), .engaged_o(engaged));
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_smp(input logic [23:0] got, input logic [23:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic reg_op(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1 req = '{wr, !wr, a, d};
        @(posedge clk_i);
        #1 req = '0;
        if (wr && a != ADDR_VBAT && regm.exists(a)) regm[a] = d;
        // Answer stands one cycle only, so look right after the taking edge
        if (!wr) begin
            chk_reg({7'h00, rvalid}, 8'h01);
            chk_reg(rdata, regm.exists(a) ? 8'(regm[a]) : 8'h00);
        end
    endtask
    task automatic set_mode(input logic [7:0] c1, input logic [7:0] c2);
        reg_op(1'b1, ADDR_CTL_ONE, c1);
        reg_op(1'b1, ADDR_CTL_TWO, c2);
        mode = int'(c1[1:0]);
    endtask
    // Knee model with release hysteresis
    task automatic set_vbat(input int c);
        int v;
        int k;
        v = 3800 + c * 12449 / 256;
        k = 3800 + regm[9] * 12449 / 256;
        below = below ? int'(v <= k + 200) : int'(v < k);
        @(posedge clk_i);
        #1 vbat = 8'(c);
        regm[6] = c;
        repeat (3) @(posedge clk_i);
    endtask
    // Exact data check only where a pending gain reduction cannot change the output
    task automatic send(input logic signed [23:0] x, input logic exact);
        // Tracking cap model, zero when unused
        expq.push_back((mode == 2 && below != 0) ? 0 : (cap != 0 && int'(x) > cap) ? cap : int'(x));
        @(posedge clk_i);
        #1 go = 1'b1;
        din = x;
        @(posedge clk_i);
        #1 go = 1'b0;
        @(posedge clk_i);
        #1 chk_reg({7'h00, smp_out.valid}, 8'h01);
        if (exact) chk_smp(smp_out.data, 24'(expq.pop_front()));
        else chk_reg({7'h00, engaged}, 8'h01);
        if (!exact) void'(expq.pop_front());
    endtask
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        conclude();
    end
    initial begin
        seed = 32'h5a6e_4e02;
        reset_n_i = 1'b0;
        req = '0;
        go = 1'b0;
        din = '0;
        vbat = 8'hFF;
        n_mismatch = 0;
        tests_run = 0;
        below = 0;
        cap = 0;
        regm[6] = 8'hFF;
        regm[7] = 8'hA4;
        regm[8] = 8'h51;
        regm[9] = 8'h22;
        repeat (4) @(posedge clk_i);
        #1 reset_n_i = 1'b1;
        for (int a = 4; a < 12; a++) reg_op(1'b0, 8'(a), 8'h00);
        for (int a = 6; a < 11; a++) reg_op(1'b1, 8'(a), 8'($random(seed)));
        for (int a = 4; a < 12; a++) reg_op(1'b0, 8'(a), 8'h00);
        reg_op(1'b1, ADDR_KNEE, 8'h22);
        set_mode(8'h00, 8'h51);
        repeat (6) send(24'($random(seed)), 1'b1);
        set_mode(8'h01, 8'h51);
        repeat (6) send(24'($random(seed) % 65536), 1'b1);
        set_mode(8'h01, 8'h00);
        repeat (3) send(24'sh70_0000, 1'b0);
        send(-24'sh70_0000, 1'b0);
        set_mode(8'h03, 8'h00);
        repeat (3) send(24'sh70_0000, 1'b1);
        // Full threshold, so the high average left above cannot cut gain
        set_mode(8'h02, 8'hF8);
        send(24'sh00_1234, 1'b1);
        set_vbat(8'h00);
        send(24'sh00_1234, 1'b1);
        set_vbat(8'h24);
        send(24'sh00_1234, 1'b1);
        set_vbat(8'h30);
        send(24'sh00_1234, 1'b1);
        set_mode(8'h05, 8'hF8);
        set_vbat(8'h00);
        for (int s = 1; s < 3; s++) begin
            reg_op(1'b1, ADDR_CTL_TWO, 8'(8'hF7 + s));
            cap = (15000 - s * (regm[9] * 12449 / 256 - regm[6] * 12449 / 256)) * 559;
            send(24'sh7F_FFFF, 1'b1);
        end
        cap = 0;
        reg_op(1'b0, ADDR_VBAT, 8'h00);
        conclude();
    end
endmodule // lim_limiter_bench
`default_nettype wire
